// ==== shared/tps_pkg.sv ====
package tps_pkg;
   localparam int          PAD_COUNT     = 10;
   localparam int          CNT_W         = 16;
   localparam int          CLK_PERIOD_NS = 50;

   // Register byte offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;
   localparam logic [7:0]  OFS_INTERVAL  = 8'h04;
   localparam logic [7:0]  OFS_DELAYS    = 8'h08;
   localparam logic [7:0]  OFS_WINDOW    = 8'h0C;
   localparam logic [7:0]  OFS_PAD_EN    = 8'h10;
   localparam logic [7:0]  OFS_GROUP1    = 8'h14;
   localparam logic [7:0]  OFS_GROUP2    = 8'h18;
   localparam logic [7:0]  OFS_STATUS    = 8'h1C;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h20;
   localparam logic [7:0]  OFS_IRQ_MASK  = 8'h24;
   localparam logic [7:0]  OFS_THRESH    = 8'h40;
   localparam logic [7:0]  OFS_COUNT     = 8'h80;

   // Control register fields
   localparam int          CTRL_SRC_SEL  = 0;
   localparam int          CTRL_TRIGGER  = 1;
   localparam int          CTRL_BOTH_GRP = 2;
   localparam int          CTRL_INIT_LVL = 3;
   // Delay register fields
   localparam int          DLY_BIAS_LSB  = 0;
   localparam int          DLY_POWER_LSB = 8;
   // Status register fields
   localparam int          STAT_BUSY     = 16;
   localparam int          STAT_WAKE     = 17;
   // Interrupt bits
   localparam int          IRQ_DONE      = 0;
   localparam int          IRQ_WAKE      = 1;

   // Values after reset
   localparam logic [3:0]  CTRL_RST      = 4'h0;
   localparam logic [15:0] INTERVAL_RST  = 16'h0100;
   localparam logic [7:0]  BIAS_DLY_RST  = 8'h04;
   localparam logic [7:0]  POWER_DLY_RST = 8'h04;
   localparam logic [15:0] WINDOW_RST    = 16'h0100;
   localparam logic [9:0]  PAD_EN_RST    = 10'h000;
   localparam logic [9:0]  GROUP_RST     = 10'h000;
   localparam logic [15:0] THRESH_RST    = 16'h0000;
   localparam logic [1:0]  IRQ_RST       = 2'h0;

   typedef enum logic [2:0] {ST_IDLE, ST_BIAS, ST_POWER, ST_MEASURE, ST_LATCH} tps_state_t;
endpackage : tps_pkg

// ==== rtl/tps_pad_counter.sv ====
`timescale 1ns/1ps
module tps_pad_counter (
   input  wire logic                      clk,      // System clock
   input  wire logic                      rst_n,    // Async reset
   input  wire logic                      pulseIn,  // Raw pad pulse from front end
   input  wire logic                      clear,    // Zero the count
   input  wire logic                      countEn,  // Measurement window open
   output logic      [tps_pkg::CNT_W-1:0] count     // Running pulse count
);
   import tps_pkg::*;

   logic             sync1_ff;
   logic             sync2_ff;
   logic             sync3_ff;
   logic             level_ff;
   logic [CNT_W-1:0] count_ff;
   logic [CNT_W-1:0] nxt_count;
   wire              agree    = (sync2_ff == sync3_ff);
   wire              riseSeen = agree && sync2_ff && !level_ff;
   wire              atMax    = &count_ff;

   // Saturates rather than wraps so a long window never looks like a touch
   assign nxt_count = clear ? '0 :
                      (countEn && riseSeen && !atMax) ? CNT_W'(count_ff + 1'b1) : count_ff;
   assign count = count_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
         sync3_ff <= 1'b0;
         level_ff <= 1'b0;
         count_ff <= '0;
      end else begin
         sync1_ff <= pulseIn;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         level_ff <= agree ? sync2_ff : level_ff;
         count_ff <= nxt_count;
      end
   end

   property p_count_step;
      @(posedge clk) disable iff (!rst_n)
      (countEn && !clear && riseSeen && !atMax) |=> (count_ff == $past(count_ff) + 1'b1);
   endproperty
   a_count_step: assert property (p_count_step) else $error("pad count missed a pulse");
endmodule : tps_pad_counter

// ==== rtl/tps_interval_timer.sv ====
`timescale 1ns/1ps
module tps_interval_timer (
   input  wire logic        clk,      // System clock
   input  wire logic        rst_n,    // Async reset
   input  wire logic        run,      // Periodic mode and machine idle
   input  wire logic [15:0] interval, // Cycles between measurements
   output logic             tick      // One-cycle start pulse
);
   import tps_pkg::*;

   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   wire  [15:0] cntInc = 16'(cnt_ff + 16'h0001);

   // Zero interval behaves as one so the timer cannot stall
   // interval count
   assign tick    = run && (cntInc >= interval);
   assign nxt_cnt = (!run || tick) ? 16'h0000 : cntInc;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   property p_tick_spacing;
      @(posedge clk) disable iff (!rst_n)
      (!run ##1 (run && interval == 16'h0004 && !tick)[*3]) |=> (!run || interval != 16'h0004 || tick);
   endproperty
   a_tick_spacing: assert property (p_tick_spacing) else $error("interval tick not on fourth cycle");
endmodule : tps_interval_timer

// ==== rtl/tps_touch_scan.sv ====
`timescale 1ns/1ps
module tps_touch_scan (
   input  wire logic                          clk,                // Fast clock, 20 MHz
   input  wire logic                          rst_n,              // Async reset, active low
   input  wire logic [7:0]                    avs_address,        // Byte address
   input  wire logic                          avs_read,           // Read request
   input  wire logic                          avs_write,          // Write request
   input  wire logic [31:0]                   avs_writedata,      // Write data
   input  wire logic [3:0]                    avs_byteenable,     // Write lanes
   output logic      [31:0]                   avs_readdata,       // Read data
   output logic                               avs_waitrequest,    // Stall
   input  wire logic [tps_pkg::PAD_COUNT-1:0] padPulseOut,        // Pad pulses
   output logic                               touchBiasPowerUp,   // Bias enable
   output logic      [tps_pkg::PAD_COUNT-1:0] padPowerUp,         // Pad power-up
   output logic      [tps_pkg::PAD_COUNT-1:0] padChargeStart,     // Pad charge start
   output logic                               initialLevelSelect, // Swing start level
   output logic                               wakeUp,             // Wake condition level
   output logic                               irq                 // Interrupt level
);
   import tps_pkg::*;

   function automatic logic [31:0] beMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return res;
   endfunction : beMerge

   function automatic logic inPadBlock(input logic [7:0] addr, input logic [7:0] base);
      return (addr[7:6] == base[7:6]) && (addr[5:2] < 4'(PAD_COUNT)) && (addr[1:0] == 2'b00);
   endfunction : inPadBlock

   // Bus slave: one wait cycle on every access
   logic        ack_ff;
   logic [31:0] readdata_ff;
   wire         access  = avs_read || avs_write;
   wire         wrTaken = avs_write && ack_ff;
   wire         rdTaken = avs_read && ack_ff;
   wire  [3:0]  padSlot = avs_address[5:2];
   assign avs_waitrequest = access && !ack_ff;
   assign avs_readdata    = readdata_ff;

   wire wrCtrl     = wrTaken && (avs_address == OFS_CTRL);
   wire wrInterval = wrTaken && (avs_address == OFS_INTERVAL);
   wire wrDelays   = wrTaken && (avs_address == OFS_DELAYS);
   wire wrWindow   = wrTaken && (avs_address == OFS_WINDOW);
   wire wrPadEn    = wrTaken && (avs_address == OFS_PAD_EN);
   wire wrGroup1   = wrTaken && (avs_address == OFS_GROUP1);
   wire wrGroup2   = wrTaken && (avs_address == OFS_GROUP2);
   wire wrIrqMask  = wrTaken && (avs_address == OFS_IRQ_MASK);
   wire wrThresh   = wrTaken && inPadBlock(avs_address, OFS_THRESH);
   wire rdIrqStat  = rdTaken && (avs_address == OFS_IRQ_STAT);

   // Configuration
   logic [3:0]       ctrl_ff;
   logic [15:0]      interval_ff;
   logic [7:0]       biasDly_ff;
   logic [7:0]       powerDly_ff;
   logic [15:0]      window_ff;
   logic [9:0]       padEn_ff;
   logic [9:0]       group1_ff;
   logic [9:0]       group2_ff;
   logic [1:0]       irqMask_ff;
   logic [CNT_W-1:0] thresh_ff [PAD_COUNT];

   wire [31:0] ctrlMerged  = beMerge({28'h0, ctrl_ff}, avs_writedata, avs_byteenable);
   wire [31:0] delayMerged = beMerge({16'h0, powerDly_ff, biasDly_ff}, avs_writedata, avs_byteenable);
   wire        srcSel      = ctrl_ff[CTRL_SRC_SEL];
   wire        bothGroups  = ctrl_ff[CTRL_BOTH_GRP];
   wire        softTrig    = wrCtrl && ctrlMerged[CTRL_TRIGGER] && ctrlMerged[CTRL_SRC_SEL];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff     <= CTRL_RST;
         interval_ff <= INTERVAL_RST;
         biasDly_ff  <= BIAS_DLY_RST;
         powerDly_ff <= POWER_DLY_RST;
         window_ff   <= WINDOW_RST;
         padEn_ff    <= PAD_EN_RST;
         group1_ff   <= GROUP_RST;
         group2_ff   <= GROUP_RST;
         irqMask_ff  <= IRQ_RST;
      end else begin
         // Trigger bit is a strobe and never stored
         if (wrCtrl) ctrl_ff <= ctrlMerged[3:0] & ~(4'h1 << CTRL_TRIGGER);
         if (wrInterval) interval_ff <= 16'(beMerge({16'h0, interval_ff}, avs_writedata, avs_byteenable));
         if (wrDelays) {powerDly_ff, biasDly_ff} <= delayMerged[15:0];
         if (wrWindow) window_ff <= 16'(beMerge({16'h0, window_ff}, avs_writedata, avs_byteenable));
         if (wrPadEn) padEn_ff <= 10'(beMerge({22'h0, padEn_ff}, avs_writedata, avs_byteenable));
         if (wrGroup1) group1_ff <= 10'(beMerge({22'h0, group1_ff}, avs_writedata, avs_byteenable));
         if (wrGroup2) group2_ff <= 10'(beMerge({22'h0, group2_ff}, avs_writedata, avs_byteenable));
         if (wrIrqMask) irqMask_ff <= 2'(beMerge({30'h0, irqMask_ff}, avs_writedata, avs_byteenable));
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PAD_COUNT; i++) thresh_ff[i] <= THRESH_RST;
      end else if (wrThresh) begin
         thresh_ff[padSlot] <= 16'(beMerge({16'h0, thresh_ff[padSlot]}, avs_writedata, avs_byteenable));
      end
   end

   // Sequencer
   tps_state_t  state_ff;
   tps_state_t  nxt_state;
   logic [15:0] stepCnt_ff;
   logic [15:0] nxt_stepCnt;
   logic        pending_ff;
   logic        initLvl_ff;
   logic        timerTick;
   wire  [15:0] stepInc  = 16'(stepCnt_ff + 16'h0001);
   wire         isIdle   = (state_ff == ST_IDLE);
   wire         startReq = pending_ff || (timerTick && !srcSel);
   wire         takeStart = isIdle && startReq;

   tps_interval_timer u_timer (
      .clk      (clk),
      .rst_n    (rst_n),
      .run      (isIdle && !srcSel),
      .interval (interval_ff),
      .tick     (timerTick)
   );

   always_comb begin
      nxt_state   = state_ff;
      nxt_stepCnt = stepInc;
      case (state_ff)
         ST_IDLE: begin
            nxt_stepCnt = 16'h0000;
            if (startReq) nxt_state = ST_BIAS;
         end
         ST_BIAS: begin
            if (stepCnt_ff >= {8'h00, biasDly_ff}) begin
               nxt_state   = ST_POWER;
               nxt_stepCnt = 16'h0000;
            end
         end
         ST_POWER: begin
            if (stepCnt_ff >= {8'h00, powerDly_ff}) begin
               nxt_state   = ST_MEASURE;
               nxt_stepCnt = 16'h0000;
            end
         end
         ST_MEASURE: begin
            if (stepInc >= window_ff) begin
               nxt_state   = ST_LATCH;
               nxt_stepCnt = 16'h0000;
            end
         end
         ST_LATCH: begin
            nxt_state   = ST_IDLE;
            nxt_stepCnt = 16'h0000;
         end
         default: begin
            nxt_state   = ST_IDLE;
            nxt_stepCnt = 16'h0000;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= ST_IDLE;
         stepCnt_ff <= 16'h0000;
         pending_ff <= 1'b0;
         initLvl_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         stepCnt_ff <= nxt_stepCnt;
         pending_ff <= softTrig || (pending_ff && !takeStart);
         if (takeStart) initLvl_ff <= ctrl_ff[CTRL_INIT_LVL];
      end
   end

   wire measuring = (state_ff == ST_MEASURE);
   wire powered   = (state_ff == ST_POWER) || measuring;
   assign touchBiasPowerUp   = !isIdle && (state_ff != ST_LATCH);
   assign padPowerUp         = padEn_ff & {PAD_COUNT{powered}};
   assign padChargeStart     = padEn_ff & {PAD_COUNT{measuring}};
   assign initialLevelSelect = initLvl_ff;

   // Pulse counters and results
   logic [CNT_W-1:0] liveCount [PAD_COUNT];
   logic [CNT_W-1:0] result_ff [PAD_COUNT];
   logic [9:0]       touchNow;
   logic [9:0]       touched_ff;

   genvar g;
   generate
      for (g = 0; g < PAD_COUNT; g++) begin : gen_pad
         tps_pad_counter u_cnt (
            .clk     (clk),
            .rst_n   (rst_n),
            .pulseIn (padPulseOut[g]),
            .clear   (takeStart),
            .countEn (measuring && padEn_ff[g]),
            .count   (liveCount[g])
         );
         assign touchNow[g] = padEn_ff[g] && (liveCount[g] < thresh_ff[g]);
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < PAD_COUNT; i++) result_ff[i] <= '0;
         touched_ff <= 10'h000;
      end else if (state_ff == ST_LATCH) begin
         for (int i = 0; i < PAD_COUNT; i++) result_ff[i] <= liveCount[i];
         touched_ff <= touchNow;
      end
   end

   wire hitGroup1 = |(touched_ff & group1_ff);
   wire hitGroup2 = |(touched_ff & group2_ff);
   assign wakeUp = hitGroup1 && (!bothGroups || hitGroup2);
   wire wakeAtLatch = (|(touchNow & group1_ff)) && (!bothGroups || |(touchNow & group2_ff));

   // Interrupt status, cleared by reading it; a new event wins over the clear
   logic [1:0] irqStat_ff;
   wire  [1:0] irqEvent = {(state_ff == ST_LATCH) && wakeAtLatch, state_ff == ST_LATCH};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irqStat_ff <= IRQ_RST;
      end else begin
         irqStat_ff <= irqEvent | (irqStat_ff & {2{!rdIrqStat}});
      end
   end
   assign irq = |(irqStat_ff & irqMask_ff);

   // Read path
   logic [31:0] readMux;
   always_comb begin
      readMux = 32'h0000_0000;
      case (avs_address)
         OFS_CTRL:     readMux = {28'h0, ctrl_ff};
         OFS_INTERVAL: readMux = {16'h0, interval_ff};
         OFS_DELAYS:   readMux = {16'h0, powerDly_ff, biasDly_ff};
         OFS_WINDOW:   readMux = {16'h0, window_ff};
         OFS_PAD_EN:   readMux = {22'h0, padEn_ff};
         OFS_GROUP1:   readMux = {22'h0, group1_ff};
         OFS_GROUP2:   readMux = {22'h0, group2_ff};
         OFS_STATUS:   readMux = {14'h0, wakeUp, !isIdle, 6'h0, touched_ff};
         OFS_IRQ_STAT: readMux = {30'h0, irqStat_ff};
         OFS_IRQ_MASK: readMux = {30'h0, irqMask_ff};
         default: begin
            if (inPadBlock(avs_address, OFS_THRESH)) readMux = {16'h0, thresh_ff[padSlot]};
            else if (inPadBlock(avs_address, OFS_COUNT)) readMux = {16'h0, result_ff[padSlot]};
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff      <= 1'b0;
         readdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff      <= access && !ack_ff;
         if (avs_read && !ack_ff) readdata_ff <= readMux;
      end
   end

   property p_soft_start;
      @(posedge clk) disable iff (!rst_n)
      (softTrig && isIdle && !pending_ff) |=> ##1 (state_ff == ST_BIAS);
   endproperty
   a_soft_start: assert property (p_soft_start) else $error("soft trigger did not start");

   property p_no_self_start;
      @(posedge clk) disable iff (!rst_n)
      (srcSel && isIdle && !pending_ff) |=> (state_ff == ST_IDLE);
   endproperty
   a_no_self_start: assert property (p_no_self_start) else $error("start without trigger");

   property p_periodic;
      @(posedge clk) disable iff (!rst_n)
      (timerTick && !srcSel && isIdle) |=> (state_ff == ST_BIAS) ##1 touchBiasPowerUp;
   endproperty
   a_periodic: assert property (p_periodic) else $error("timer tick did not start");

   property p_bias_first;
      @(posedge clk) disable iff (!rst_n)
      (padPowerUp != 10'h000) |-> touchBiasPowerUp && $past(touchBiasPowerUp);
   endproperty
   a_bias_first: assert property (p_bias_first) else $error("pad powered before bias");

   property p_pad_gate;
      @(posedge clk) disable iff (!rst_n)
      ((padPowerUp | padChargeStart) & ~padEn_ff) == 10'h000 && ((padChargeStart & ~padPowerUp) == 10'h000);
   endproperty
   a_pad_gate: assert property (p_pad_gate) else $error("disabled pad exercised");

   property p_window_len;
      @(posedge clk) disable iff (!rst_n)
      ($rose(measuring) && window_ff == 16'h0004 && !wrWindow) |->
         measuring[*4] ##1 (state_ff == ST_LATCH);
   endproperty
   a_window_len: assert property (p_window_len) else $error("measurement window length wrong");

   property p_latch_results;
      @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_LATCH) |=> (touched_ff == $past(touchNow)) && (result_ff[0] == $past(liveCount[0]));
   endproperty
   a_latch_results: assert property (p_latch_results) else $error("results not latched");

   property p_hold_results;
      @(posedge clk) disable iff (!rst_n)
      (state_ff != ST_LATCH) |=> $stable(touched_ff) && $stable(result_ff[PAD_COUNT-1]);
   endproperty
   a_hold_results: assert property (p_hold_results) else $error("results changed mid-scan");

   property p_wake_group1;
      @(posedge clk) disable iff (!rst_n)
      wakeUp |-> |(touched_ff & group1_ff);
   endproperty
   a_wake_group1: assert property (p_wake_group1) else $error("wake without group one touch");

   property p_wake_both;
      @(posedge clk) disable iff (!rst_n)
      (wakeUp && bothGroups) |-> |(touched_ff & group2_ff);
   endproperty
   a_wake_both: assert property (p_wake_both) else $error("wake without group two touch");

   property p_wake_irq;
      @(posedge clk) disable iff (!rst_n)
      (state_ff == ST_LATCH && wakeAtLatch && irqMask_ff[IRQ_WAKE]) |=> irq && irqStat_ff[IRQ_WAKE];
   endproperty
   a_wake_irq: assert property (p_wake_irq) else $error("touch interrupt missing");

   property p_init_level;
      @(posedge clk) disable iff (!rst_n)
      (!isIdle && !takeStart) |=> $stable(initialLevelSelect);
   endproperty
   a_init_level: assert property (p_init_level) else $error("initial level moved mid-scan");
endmodule : tps_touch_scan

// ==== tb/tps_pad_model.sv ====
`timescale 1ns/1ps
module tps_pad_model (
   input  wire logic       clk,         // Fast clock
   input  wire logic [9:0] chargeStart, // Charge start per pad
   input  wire logic [9:0] touched,     // Pads under a finger
   output logic      [9:0] pulseOut = 10'h000 // Swing pulses
);
   logic [3:0] phase [10] = '{default: 4'h0};
   // A touched pad swings three times slower; idle pads toggle so a stale level never looks valid
   always @(posedge clk) begin
      for (int i = 0; i < 10; i++) begin
         if (!chargeStart[i] || phase[i] == (touched[i] ? 4'h5 : 4'h1)) begin
            pulseOut[i] <= !pulseOut[i];
            phase[i]    <= 4'h0;
         end else begin
            phase[i] <= phase[i] + 4'h1;
         end
      end
   end
endmodule : tps_pad_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import tps_pkg::*;
   logic        clk, rst_n, rd, wr, bias, ils, wake, irq, stall;
   logic [7:0]  addr;
   logic [3:0]  be;
   logic [31:0] wdata, rdata, got;
   logic [9:0]  pulses, touched, pwr, chg;
   logic        pB = 0, pP = 0, pC = 0, bad8 = 0;
   int          err_total, total_checks, nMeas, nDone, cyc, t0, tP, tC, tE, dBias, dPow, win, gap;

   tps_touch_scan u_dut (.clk(clk), .rst_n(rst_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(stall),
      .padPulseOut(pulses), .touchBiasPowerUp(bias), .padPowerUp(pwr), .padChargeStart(chg),
      .initialLevelSelect(ils), .wakeUp(wake), .irq(irq));
   tps_pad_model u_pads (.clk(clk), .chargeStart(chg), .touched(touched), .pulseOut(pulses));

   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end

   // phase lengths seen at the pins
   always @(negedge clk) begin
      cyc++;
      if (bias && !pB) begin
         nMeas++;
         t0  = cyc;
         gap = cyc - tE;
      end
      if (|pwr && !pP) tP = cyc;
      if (|pwr && !pP) dBias = cyc - t0;
      if (|chg && !pC) tC = cyc;
      if (|chg && !pC) dPow = cyc - tP;
      if (!(|chg) && pC) begin
         nDone++;
         win = cyc - tC;
         tE  = cyc;
      end
      if (pwr[8] === 1'b1) bad8 = 1;
      pB = bias;
      pP = |pwr;
      pC = |chg;
   end

   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      total_checks++;
      if (a !== e) begin
         err_total++;
         $display("Error %0t: got %h expected %h", $time, a, e);
      end
   endtask : chk

   task automatic chkr(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      total_checks++;
      if ((a >= lo && a <= hi) !== 1'b1) begin
         err_total++;
         $display("Error %0t: got %h outside %h..%h", $time, a, lo, hi);
      end
   endtask : chkr

   // Holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wr    <= w;
      rd    <= !w;
      addr  <= a;
      wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (stall !== 1'b0 && n < 20);
      // Read before this edge's updates land, so these are the values the slave presented
      got = rdata;
      if (stall !== 1'b0) chk(32'h0000_0000, 32'h0000_0001);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask : bus

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      chk(got, e);
   endtask : rdchk

   task automatic wait_done(input int n);
      for (int i = 0; i < 600 && nDone < n; i++) @(posedge clk);
      repeat (3) @(posedge clk);
      chk(nDone, n);
   endtask : wait_done

   task automatic finish_test;
      if (err_total == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : finish_test

   initial begin
      #(CLK_PERIOD_NS * 5000);
      err_total++;
      finish_test();
   end

   initial begin
      {rst_n, rd, wr, addr, wdata} = '0;
      be      = 4'hF;
      touched = 10'h201;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(OFS_INTERVAL, 32'h0000_0100);
      rdchk(OFS_DELAYS, 32'h0000_0404);
      rdchk(OFS_WINDOW, 32'h0000_0100);
      rdchk(8'h30, 32'h0000_0000);
      bus(1'b1, OFS_WINDOW, 32'h0000_0040);
      bus(1'b1, OFS_PAD_EN, 32'h0000_02FF);
      bus(1'b1, OFS_GROUP1, 32'h0000_0001);
      bus(1'b1, OFS_GROUP2, 32'h0000_0200);
      bus(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
      for (int i = 0; i < 10; i++) bus(1'b1, OFS_THRESH + 8'(4 * i), 32'h0000_000A);
      bus(1'b1, OFS_CTRL, 32'h0000_000B);
      wait_done(1);
      chk(irq, 1'b1);
      chk(ils, 1'b1);
      chk(wake, 1'b1);
      chk(dBias, 5);
      chk(dPow, 5);
      chk(win, 64);
      chk(bad8, 1'b0);
      rdchk(OFS_STATUS, 32'h0002_0201);
      bus(1'b0, OFS_COUNT, 32'h0000_0000);
      chkr(got, 4, 8);
      bus(1'b0, OFS_COUNT + 8'h04, 32'h0000_0000);
      chkr(got, 14, 18);
      rdchk(OFS_IRQ_STAT, 32'h0000_0003);
      rdchk(OFS_IRQ_STAT, 32'h0000_0000);
      chk(irq, 1'b0);
      repeat (300) @(posedge clk);
      chk(nMeas, 1);
      touched <= 10'h001;
      bus(1'b1, OFS_IRQ_MASK, 32'h0000_0002);
      bus(1'b1, OFS_CTRL, 32'h0000_0007);
      wait_done(2);
      chk(irq, 1'b0);
      chk(wake, 1'b0);
      rdchk(OFS_STATUS, 32'h0000_0001);
      rdchk(OFS_IRQ_STAT, 32'h0000_0001);
      bus(1'b1, OFS_INTERVAL, 32'h0000_0004);
      bus(1'b1, OFS_WINDOW, 32'h0000_0004);
      bus(1'b1, OFS_CTRL, 32'h0000_0000);
      wait_done(4);
      chk(nMeas, 4);
      chkr(gap, 5, 8);
      chk(win, 4);
      be <= 4'h2;
      bus(1'b1, OFS_DELAYS, 32'h0000_0700);
      be <= 4'hF;
      rdchk(OFS_DELAYS, 32'h0000_0704);
      finish_test();
   end
endmodule : testbench
